// [verilog/hsc_sequence_control.sv]
// Sequencing logic of the heatseal controller with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module hsc_sequence_control #(
	parameter int unsigned CALSTEP_CYC  = hsc_pkg::T_CALSTEP_MS * hsc_pkg::CYC_PER_MS,
	parameter int unsigned UNTIMED_CYC  = hsc_pkg::T_UNTIMED_MS * hsc_pkg::CYC_PER_MS,
	parameter int unsigned REINIT_CYC   = hsc_pkg::T_REINIT_MS * hsc_pkg::CYC_PER_MS,
	parameter int unsigned CONTACT_CYC  = hsc_pkg::T_CONTACT_MS * hsc_pkg::CYC_PER_MS,
	parameter int unsigned HOLD_CYC     = hsc_pkg::T_HOLD_MS * hsc_pkg::CYC_PER_MS,
	parameter int unsigned BLANK_CYC    = hsc_pkg::T_BLANK_MS * hsc_pkg::CYC_PER_MS,
	parameter int unsigned DEBOUNCE_CYC = hsc_pkg::T_DEBOUNCE_MS * hsc_pkg::CYC_PER_MS,
	parameter int unsigned UNIT_CYC     = hsc_pkg::T_UNIT_MS * hsc_pkg::CYC_PER_MS
) (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic                  ce,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	input  wire hsc_pkg::hsc_pins_type pins,
	input  wire hsc_pkg::hsc_meas_type meas,
	output hsc_pkg::hsc_out_type       status,
	output logic [15:0]                actualTempOut,
	output logic [15:0]                displayTemp,
	output logic [3:0]                 calCountdown
);
	hsc_pkg::hsc_state_type state;
	logic [hsc_pkg::NPINS-1:0] syncA, syncB, clean, cleanD;
	logic [31:0]  dbCnt [hsc_pkg::NPINS];
	logic [1:0]   timeMode, holdMode;
	logic         manualCycle;
	logic [15:0]  setPoint;
	logic [7:0]   lowerMargin, upperMargin;
	logic [9:0]   delayUnits, heatUnits, coolUnits;
	logic [29:0]  cycleCount;
	logic [31:0]  phaseCnt, stepCnt, contactCnt, holdCnt, blankCnt;
	logic         lockStart, lockRelease, warmMsg, errLock, everOk;
	logic         contactWatch, heldValid, blanking;
	logic [15:0]  heldTemp;
	logic         wrPend;
	logic [7:0]   wrAddr;
	logic         calWrite, confirmWrite;
	logic         startRise, calRise, manualRise, resetRise, resetFall;
	logic         calRequest, calBlocked, startAlarm, heatAllowed, heatNow, phaseEnd;
	logic [31:0]  delayCyc, heatCyc, coolCyc;
	logic [16:0]  winLow, winHigh;
	logic [15:0]  next_display;
	localparam hsc_pkg::hsc_state_type S_IDLE = hsc_pkg::S_IDLE, S_CAL = hsc_pkg::S_CAL,
		S_UNTIMED = hsc_pkg::S_UNTIMED, S_DELAY = hsc_pkg::S_DELAY, S_HEAT = hsc_pkg::S_HEAT,
		S_COOL = hsc_pkg::S_COOL, S_INIT = hsc_pkg::S_INIT, S_MANUAL = hsc_pkg::S_MANUAL;

	// Two-flop synchroniser and debounce per input
	generate
		for (genvar i = 0; i < hsc_pkg::NPINS; i++) begin : g_pin
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					syncA[i] <= 1'b0;
					syncB[i] <= 1'b0;
					clean[i] <= 1'b0;
					dbCnt[i] <= 32'h00000000;
				end else if (ce) begin
					syncA[i] <= pins[i];
					syncB[i] <= syncA[i];
					if (syncB[i] == clean[i]) begin
						dbCnt[i] <= 32'h00000000;
					end else if (dbCnt[i] >= DEBOUNCE_CYC - 1) begin
						clean[i] <= syncB[i];
						dbCnt[i] <= 32'h00000000;
					end else begin
						dbCnt[i] <= dbCnt[i] + 32'h00000001;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cleanD <= '0;
		end else if (ce) begin
			cleanD <= clean;
		end
	end

	assign startRise  = clean[0] & ~cleanD[0];
	assign resetRise  = clean[1] & ~cleanD[1];
	assign resetFall  = ~clean[1] & cleanD[1];
	assign calRise    = clean[2] & ~cleanD[2];
	assign manualRise = clean[4] & ~cleanD[4];
	assign calRequest = calRise | calWrite;

	// Error classes that block calibration or start
	always_comb begin
		calBlocked = (meas.errorCode >= hsc_pkg::ERR_201 && meas.errorCode <= hsc_pkg::ERR_203)
			|| meas.errorCode == hsc_pkg::ERR_801
			|| (meas.errorCode >= hsc_pkg::ERR_900 && meas.errorCode <= hsc_pkg::ERR_999);
		if (!everOk && meas.errorCode >= hsc_pkg::ERR_101 && meas.errorCode <= hsc_pkg::ERR_103) begin
			calBlocked = 1'b1;
		end
		startAlarm = meas.alarmActive && ((meas.errorCode >= hsc_pkg::ERR_104
			&& meas.errorCode <= hsc_pkg::ERR_105)
			|| (meas.errorCode >= hsc_pkg::ERR_111 && meas.errorCode <= hsc_pkg::ERR_113)
			|| meas.errorCode == hsc_pkg::ERR_211);
	end

	assign heatAllowed = (setPoint > hsc_pkg::MIN_SETPOINT) && !startAlarm;
	assign delayCyc = 32'(delayUnits) * UNIT_CYC;
	assign heatCyc  = 32'(heatUnits) * UNIT_CYC;
	assign coolCyc  = 32'(coolUnits) * UNIT_CYC;
	assign phaseEnd = (state == S_HEAT && phaseCnt >= heatCyc)
		|| (state == S_UNTIMED && !clean[0]);

	// Sequence state machine
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= S_INIT;
			phaseCnt <= 32'h00000000;
			stepCnt <= 32'h00000000;
			calCountdown <= 4'h0;
		end else if (ce) begin
			phaseCnt <= phaseCnt + 32'h00000001;
			if (clean[1] && state != S_CAL) begin
				state <= S_INIT;
				phaseCnt <= 32'h00000000;
			end else begin
				case (state)
					S_INIT: begin
						if (phaseCnt >= REINIT_CYC - 1) begin
							state <= S_IDLE;
						end
					end
					S_IDLE: begin
						phaseCnt <= 32'h00000000;
						if (calRequest && !clean[0] && !clean[3] && !meas.coolingFast
							&& !calBlocked) begin
							state <= S_CAL;
							calCountdown <= hsc_pkg::CAL_START;
							stepCnt <= 32'h00000000;
						end else if (startRise && heatAllowed) begin
							if (timeMode == hsc_pkg::TMODE_OFF) begin
								state <= S_UNTIMED;
							end else if (delayUnits == 10'h000) begin
								state <= S_HEAT;
							end else begin
								state <= S_DELAY;
							end
						end else if (manualRise && heatAllowed) begin
							state <= manualCycle ? S_DELAY : S_MANUAL;
						end
					end
					S_CAL: begin
						stepCnt <= stepCnt + 32'h00000001;
						if (stepCnt >= CALSTEP_CYC - 1) begin
							stepCnt <= 32'h00000000;
							if (calCountdown == 4'h0) begin
								state <= S_IDLE;
							end else begin
								calCountdown <= calCountdown - 4'h1;
							end
						end
					end
					S_UNTIMED: begin
						if (!clean[0]) begin
							state <= S_IDLE;
						end
					end
					S_MANUAL: begin
						if (!clean[4]) begin
							state <= S_IDLE;
						end
					end
					S_DELAY: begin
						if (phaseCnt >= delayCyc) begin
							state <= S_HEAT;
							phaseCnt <= 32'h00000000;
						end
					end
					S_HEAT: begin
						if (phaseCnt >= heatCyc) begin
							state <= S_COOL;
							phaseCnt <= 32'h00000000;
						end
					end
					S_COOL: begin
						if (phaseCnt >= coolCyc) begin
							state <= S_IDLE;
						end
					end
					default: state <= S_IDLE;
				endcase
			end
		end
	end

	// Heating cut after the continuous limit in untimed and manual heating
	assign heatNow = (state == S_HEAT)
		|| ((state == S_UNTIMED || state == S_MANUAL) && phaseCnt < UNTIMED_CYC);

	// Calibration lockout messages and power-up history
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lockStart <= 1'b0;
			lockRelease <= 1'b0;
			warmMsg <= 1'b0;
			errLock <= 1'b0;
			everOk <= 1'b0;
		end else if (ce) begin
			if (calRequest && state == S_IDLE) begin
				lockStart <= clean[0];
				lockRelease <= clean[3];
				warmMsg <= meas.coolingFast;
				errLock <= calBlocked;
			end
			if (state == S_COOL && phaseCnt >= coolCyc) begin
				everOk <= 1'b1;
			end else if (state == S_UNTIMED && !clean[0]) begin
				everOk <= 1'b1;
			end
		end
	end

	// Cycle counter, a confirm in the same cycle as a count restarts it at 1
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cycleCount <= 30'h00000000;
		end else if (ce) begin
			if (startRise && state != S_CAL) begin
				if (confirmWrite || cycleCount >= hsc_pkg::COUNT_MAX) begin
					cycleCount <= 30'h00000001;
				end else begin
					cycleCount <= cycleCount + 30'h00000001;
				end
			end else if (confirmWrite) begin
				cycleCount <= 30'h00000000;
			end
		end
	end

	// Loop contactor watch after reset release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			contactWatch <= 1'b0;
			contactCnt <= 32'h00000000;
			status.contactorAlarm <= 1'b0;
		end else if (ce) begin
			if (resetRise) begin
				status.contactorAlarm <= 1'b0;
				contactWatch <= 1'b0;
			end else if (resetFall) begin
				contactWatch <= 1'b1;
				contactCnt <= 32'h00000000;
			end else if (contactWatch) begin
				contactCnt <= contactCnt + 32'h00000001;
				if (clean[5]) begin
					contactWatch <= 1'b0;
				end else if (contactCnt >= CONTACT_CYC - 1) begin
					contactWatch <= 1'b0;
					status.contactorAlarm <= 1'b1;
				end
			end
		end
	end

	// Hold value, timed hold and lamp blanking
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			heldValid <= 1'b0;
			heldTemp <= 16'h0000;
			holdCnt <= 32'h00000000;
			blankCnt <= 32'h00000000;
			blanking <= 1'b0;
		end else if (ce) begin
			if (holdCnt != 32'h00000000) begin
				holdCnt <= holdCnt - 32'h00000001;
			end
			if (blankCnt != 32'h00000000) begin
				blankCnt <= blankCnt - 32'h00000001;
			end else begin
				blanking <= 1'b0;
			end
			if (phaseEnd) begin
				heldValid <= 1'b1;
				heldTemp <= meas.actualTemp;
				holdCnt <= HOLD_CYC;
				blanking <= 1'b1;
				blankCnt <= BLANK_CYC - 1;
			end
		end
	end

	always_comb begin
		next_display = meas.actualTemp;
		if (heldValid && (holdMode == hsc_pkg::HMODE_ON
			|| (holdMode == hsc_pkg::HMODE_2S && holdCnt != 32'h00000000))) begin
			next_display = heldTemp;
		end
	end

	assign winLow  = {1'b0, setPoint} - {9'h000, lowerMargin};
	assign winHigh = {1'b0, setPoint} + {9'h000, upperMargin};

	// Registered outputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status.heatEnable <= 1'b0;
			status.measureEnable <= 1'b0;
			status.alarmRelay <= 1'b0;
			status.alarmClear <= 1'b0;
			status.tempOk <= 1'b0;
			status.auxRelay <= 1'b0;
			status.holdLamp <= 1'b0;
			status.calibrating <= 1'b0;
			actualTempOut <= 16'h0000;
			displayTemp <= 16'h0000;
		end else if (ce) begin
			status.heatEnable <= heatNow && state != S_CAL;
			status.measureEnable <= !clean[1] || state == S_CAL;
			status.alarmClear <= resetRise;
			if (resetRise) begin
				status.alarmRelay <= 1'b0;
			end else if (startRise && startAlarm && state != S_CAL) begin
				status.alarmRelay <= 1'b1;
			end
			status.tempOk <= !meas.alarmActive && ({1'b0, meas.actualTemp} >= winLow)
				&& ({1'b0, meas.actualTemp} <= winHigh);
			status.auxRelay <= state == S_DELAY || state == S_HEAT || state == S_COOL;
			status.holdLamp <= heldValid && (holdMode == hsc_pkg::HMODE_ON
				|| (holdMode == hsc_pkg::HMODE_2S && holdCnt != 32'h00000000))
				&& !blanking;
			status.calibrating <= state == S_CAL;
			actualTempOut <= (state == S_CAL) ? 16'h0000 : meas.actualTemp;
			displayTemp <= next_display;
		end
	end

	// AHB-Lite slave, zero wait states
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign calWrite = wrPend && wrAddr == hsc_pkg::REG_CTRL && hwdata[hsc_pkg::CTRL_CAL];
	assign confirmWrite = wrPend && wrAddr == hsc_pkg::REG_CTRL && hwdata[hsc_pkg::CTRL_CONFIRM];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wrPend <= 1'b0;
			wrAddr <= 8'h00;
			hrdata <= 32'h00000000;
		end else if (ce && hready) begin
			wrPend <= hsel && htrans[1] && hwrite;
			wrAddr <= haddr[7:0];
			hrdata <= 32'h00000000;
			if (hsel && htrans[1] && !hwrite) begin
				case (haddr[7:0])
					hsc_pkg::REG_CTRL:   hrdata <= {27'h0000000, manualCycle, holdMode, timeMode};
					hsc_pkg::REG_SETPT:  hrdata <= {16'h0000, setPoint};
					hsc_pkg::REG_WINDOW: hrdata <= {16'h0000, upperMargin, lowerMargin};
					hsc_pkg::REG_TIMES:  hrdata <= {6'h00, heatUnits, 6'h00, delayUnits};
					hsc_pkg::REG_COOL:   hrdata <= {22'h000000, coolUnits};
					hsc_pkg::REG_STATUS: hrdata <= {16'h0000, status.contactorAlarm,
						everOk, errLock, warmMsg, lockRelease, lockStart, 3'(state), calCountdown,
						1'b0, status.heatEnable, status.tempOk};
					hsc_pkg::REG_COUNT:  hrdata <= {2'h0, cycleCount};
					hsc_pkg::REG_DISP:   hrdata <= {15'h0000, status.holdLamp, displayTemp};
					default:             hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timeMode <= hsc_pkg::TMODE_OFF;
			holdMode <= hsc_pkg::HMODE_OFF;
			manualCycle <= 1'b0;
			setPoint <= hsc_pkg::SETPT_RST;
			lowerMargin <= 8'h00;
			upperMargin <= 8'h00;
			delayUnits <= 10'h000;
			heatUnits <= 10'h000;
			coolUnits <= 10'h000;
		end else if (ce && wrPend) begin
			case (wrAddr)
				hsc_pkg::REG_CTRL: begin
					timeMode <= hwdata[hsc_pkg::CTRL_TMODE +: 2];
					holdMode <= hwdata[hsc_pkg::CTRL_HMODE +: 2];
					manualCycle <= hwdata[hsc_pkg::CTRL_MSTEP];
				end
				hsc_pkg::REG_SETPT: setPoint <= hwdata[15:0];
				hsc_pkg::REG_WINDOW: begin
					lowerMargin <= hwdata[7:0];
					upperMargin <= hwdata[hsc_pkg::WIN_UPPER +: 8];
				end
				hsc_pkg::REG_TIMES: begin
					delayUnits <= hwdata[9:0];
					heatUnits <= hwdata[hsc_pkg::TIMES_HEAT +: 10];
				end
				hsc_pkg::REG_COOL: coolUnits <= hwdata[9:0];
				default: ;
			endcase
		end
	end
endmodule // hsc_sequence_control
`default_nettype wire

// [inc/hsc_pkg.sv]
// Package with constants and carrier types of the heatseal sequence control
package hsc_pkg;
	localparam int unsigned CLK_HZ      = 200_000_000;
	localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
	localparam int unsigned T_CALSTEP_MS = 1000;
	localparam int unsigned T_UNTIMED_MS = 5000;
	localparam int unsigned T_REINIT_MS  = 500;
	localparam int unsigned T_CONTACT_MS = 50;
	localparam int unsigned T_HOLD_MS    = 2000;
	localparam int unsigned T_BLANK_MS   = 100;
	localparam int unsigned T_DEBOUNCE_MS = 1;
	localparam int unsigned T_UNIT_MS    = 10;
	localparam logic [3:0]  CAL_START    = 4'hD;
	localparam logic [15:0] MIN_SETPOINT = 16'h0028;
	localparam logic [29:0] COUNT_MAX    = 30'h3B9AC9FF;
	localparam logic [9:0]  ERR_101 = 10'h065;
	localparam logic [9:0]  ERR_103 = 10'h067;
	localparam logic [9:0]  ERR_104 = 10'h068;
	localparam logic [9:0]  ERR_105 = 10'h069;
	localparam logic [9:0]  ERR_111 = 10'h06F;
	localparam logic [9:0]  ERR_113 = 10'h071;
	localparam logic [9:0]  ERR_201 = 10'h0C9;
	localparam logic [9:0]  ERR_203 = 10'h0CB;
	localparam logic [9:0]  ERR_211 = 10'h0D3;
	localparam logic [9:0]  ERR_801 = 10'h321;
	localparam logic [9:0]  ERR_900 = 10'h384;
	localparam logic [9:0]  ERR_999 = 10'h3E7;
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_SETPT  = 8'h04;
	localparam logic [7:0] REG_WINDOW = 8'h08;
	localparam logic [7:0] REG_TIMES  = 8'h0C;
	localparam logic [7:0] REG_COOL   = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_COUNT  = 8'h18;
	localparam logic [7:0] REG_DISP   = 8'h1C;
	localparam int CTRL_TMODE  = 0;
	localparam int CTRL_HMODE  = 2;
	localparam int CTRL_MSTEP  = 4;
	localparam int CTRL_CAL    = 8;
	localparam int CTRL_CONFIRM = 9;
	localparam int TIMES_HEAT  = 16;
	localparam int WIN_UPPER   = 8;
	localparam logic [1:0] TMODE_OFF = 2'h0;
	localparam logic [1:0] HMODE_OFF = 2'h0;
	localparam logic [1:0] HMODE_ON  = 2'h1;
	localparam logic [1:0] HMODE_2S  = 2'h2;
	localparam logic [15:0] SETPT_RST = 16'h0000;
	localparam int NPINS = 6;
	typedef enum logic [2:0] {
		S_IDLE    = 3'b000,
		S_CAL     = 3'b001,
		S_UNTIMED = 3'b010,
		S_DELAY   = 3'b011,
		S_HEAT    = 3'b100,
		S_COOL    = 3'b101,
		S_INIT    = 3'b110,
		S_MANUAL  = 3'b111
	} hsc_state_type;
	typedef struct packed {
		logic loopContactor;
		logic manualHeatKey;
		logic releaseControlInput;
		logic calibrate;
		logic extReset;
		logic start;
	} hsc_pins_type;
	typedef struct packed {
		logic [15:0] actualTemp;
		logic [9:0]  errorCode;
		logic        alarmActive;
		logic        coolingFast;
	} hsc_meas_type;
	typedef struct packed {
		logic heatEnable;
		logic measureEnable;
		logic alarmRelay;
		logic alarmClear;
		logic tempOk;
		logic auxRelay;
		logic holdLamp;
		logic calibrating;
		logic contactorAlarm;
	} hsc_out_type;
endpackage

// [dv/hsc_sequence_control_assertions.sv]
// Port checker of the heatseal sequence control, bound to the design
`timescale 1ns/10ps
`default_nettype none
module hsc_checker #(
	parameter int unsigned UNTIMED_CYC  = 200,
	parameter int unsigned REINIT_CYC   = 50,
	parameter int unsigned DEBOUNCE_CYC = 2
) (
	input wire logic                  clk,
	input wire logic                  resetn,
	input wire logic                  hreadyout,
	input wire logic                  hresp,
	input wire hsc_pkg::hsc_pins_type pins,
	input wire hsc_pkg::hsc_meas_type meas,
	input wire hsc_pkg::hsc_out_type  status,
	input wire logic [15:0]           actualTempOut,
	input wire logic [3:0]            calCountdown
);
	int unsigned heatRun;
	int unsigned rstRun;
	int unsigned sinceRst;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Untimed heat run, reset level run, time since reset release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			heatRun <= 0;
			rstRun <= 0;
			sinceRst <= 0;
		end else begin
			heatRun <= (status.heatEnable && !status.auxRelay) ? heatRun + 1 : 0;
			rstRun <= pins.extReset ? rstRun + 1 : 0;
			sinceRst <= pins.extReset ? 0 : ((sinceRst < REINIT_CYC) ? sinceRst + 1 : sinceRst);
		end
	end
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
	cal_noheat_a: assert property (status.calibrating |-> !status.heatEnable)
		else $error("heating during calibration");
	cal_start_a: assert property ($rose(status.calibrating)
		|-> ##[0:1] calCountdown == hsc_pkg::CAL_START) else $error("countdown not from 13");
	cal_step_a: assert property (status.calibrating && $past(status.calibrating, 2)
		&& $changed(calCountdown) |-> calCountdown == $past(calCountdown) - 4'h1)
		else $error("countdown step wrong");
	cal_zero_a: assert property (status.calibrating && $past(status.calibrating)
		|-> actualTempOut == 16'h0000) else $error("temperature out not zero");
	untimed_cap_a: assert property (heatRun <= UNTIMED_CYC + 4)
		else $error("untimed heat too long");
	reset_stop_a: assert property ((rstRun > DEBOUNCE_CYC + 6 && !status.calibrating) [*4]
		|-> !status.heatEnable && !status.measureEnable) else $error("reset did not stop");
	alarm_clear_a: assert property (status.alarmClear
		|=> !status.alarmClear ##1 !status.alarmRelay) else $error("alarm not cleared");
	reinit_a: assert property (sinceRst < REINIT_CYC |-> !status.heatEnable)
		else $error("heat during re-initialisation");
	alarm_tok_a: assert property (meas.alarmActive [*3] |-> !status.tempOk)
		else $error("temperature ok during alarm");
	cal_run_c: cover property ($rose(status.calibrating));
	alarm_c: cover property ($rose(status.alarmRelay));
	blank_c: cover property ($fell(status.holdLamp));
	contactor_c: cover property ($rose(status.contactorAlarm));
endmodule // hsc_checker
bind hsc_sequence_control hsc_checker #(
	.UNTIMED_CYC (UNTIMED_CYC),
	.REINIT_CYC  (REINIT_CYC),
	.DEBOUNCE_CYC(DEBOUNCE_CYC)
) u_hsc_checker (
	.clk          (clk),
	.resetn       (resetn),
	.hreadyout    (hreadyout),
	.hresp        (hresp),
	.pins         (pins),
	.meas         (meas),
	.status       (status),
	.actualTempOut(actualTempOut),
	.calCountdown (calCountdown)
);
`default_nettype wire

// [dv/hsc_machine_model.sv]
// Machine control model driving the control pins of the sequencer
`timescale 1ns/10ps
`default_nettype none
module hsc_machine_model #(
	parameter int unsigned CONTACT_CYC = 10
) (
	input wire logic                  clk,
	input wire logic [4:0]            req,
	input wire logic                  late,
	output var hsc_pkg::hsc_pins_type pins
);
	int unsigned relCnt = 1000;
	initial pins = '0;
	always @(posedge clk) begin
		relCnt <= req[1] ? 0 : relCnt + 1;
		// Start drops between sequences as commanded
		pins[4:0] <= req;
		// Contactor back on after reset release, prompt or late
		pins.loopContactor <= !req[1] && relCnt >= (late ? 3 * CONTACT_CYC : CONTACT_CYC / 2);
	end
endmodule // hsc_machine_model
`default_nettype wire

// [dv/hsc_tb.sv]
// Self-checking testbench of the heatseal sequence control
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int CAL = 20, UNT = 200, RI = 50, CON = 10, HLD = 40, BLK = 8, DB = 2, UN = 4;
	localparam int HE = 8, ME = 7, AR = 6, AC = 5, TOK = 4, AX = 3, HL = 2, CA = 1, CO = 0;
	logic                  clk;
	logic                  resetn = 1'b0;
	logic                  hsel = 1'b0;
	logic [31:0]           haddr = 32'h0;
	logic [1:0]            htrans = 2'h0;
	logic                  hwrite = 1'b0;
	logic [31:0]           hwdata = 32'h0;
	logic [4:0]            req = 5'h00;
	logic                  late = 1'b0;
	hsc_pkg::hsc_meas_type meas = '0;
	wire logic             hreadyout;
	wire logic             hresp;
	wire logic [31:0]      hrdata;
	hsc_pkg::hsc_pins_type pins;
	hsc_pkg::hsc_out_type  status;
	wire logic [15:0]      tempOut;
	wire logic [15:0]      dispTemp;
	wire logic [3:0]       calCount;
	logic [31:0]           rv;
	int                    n;
	int                    errCount = 0;
	int                    checkCount = 0;
	hsc_machine_model #(.CONTACT_CYC(CON)) u_hsc_machine_model (
		.clk (clk),
		.req (req),
		.late(late),
		.pins(pins)
	);
	hsc_sequence_control #(.CALSTEP_CYC(CAL), .UNTIMED_CYC(UNT), .REINIT_CYC(RI),
		.CONTACT_CYC(CON), .HOLD_CYC(HLD), .BLANK_CYC(BLK), .DEBOUNCE_CYC(DB), .UNIT_CYC(UN)
	) u_hsc_sequence_control (
		.clk(clk), .resetn(resetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins), .meas(meas),
		.status(status), .actualTempOut(tempOut), .displayTemp(dispTemp), .calCountdown(calCount)
	);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] act, input logic [31:0] exp);
		checkCount++;
		if (act !== exp) begin
			errCount++;
			$display("[FAIL] %0t got %h want %h", $time, act, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rv & m, e);
	endtask
	task automatic wt(input int i, input logic v, input int lim);
		logic [8:0] s;
		n = 0;
		s = status;
		while (s[i] !== v && n < lim) begin
			@(posedge clk);
			n++;
			s = status;
		end
		chk(32'(s[i]), 32'(v));
	endtask
	task automatic t_regs();
		rdc(hsc_pkg::REG_STATUS, 32'h380, 32'h300);
		rdc(hsc_pkg::REG_SETPT, 32'hFFFF, 32'(hsc_pkg::SETPT_RST));
		rdc(8'h20, 32'hFFFFFFFF, 32'h0);
		req[0] <= 1'b1;
		cyc(RI + 10);
		rdc(hsc_pkg::REG_STATUS, 32'h382, 32'h0);
		req[0] <= 1'b0;
		cyc(10);
		$display("t_regs done");
	endtask
	task automatic t_lock();
		for (int i = 0; i < 4; i++) begin
			case (i)
				0: req <= 5'h05;
				1: req[3] <= 1'b1;
				2: meas.coolingFast <= 1'b1;
				default: meas.errorCode <= 10'h065;
			endcase
			cyc(10);
			req[2] <= 1'b1;
			cyc(12);
			chk(32'(status.calibrating), 32'h0);
			rdc(hsc_pkg::REG_STATUS, 32'h1 << (10 + i), 32'h1 << (10 + i));
			req <= 5'h00;
			meas <= '0;
			cyc(12);
		end
		$display("t_lock done");
	endtask
	task automatic t_untimed();
		wr(hsc_pkg::REG_CTRL, 32'h204);
		rdc(hsc_pkg::REG_COUNT, 32'h3FFFFFFF, 32'h0);
		wr(hsc_pkg::REG_SETPT, 32'h64);
		meas.actualTemp <= 16'h0077;
		req[0] <= 1'b1;
		wt(HE, 1'b1, 15);
		wt(HE, 1'b0, UNT + 10);
		chk(32'(n >= UNT - 4), 32'h1);
		req[0] <= 1'b0;
		cyc(15);
		meas.actualTemp <= 16'h0033;
		cyc(10);
		chk(32'(dispTemp), 32'h77);
		chk(32'(status.holdLamp), 32'h1);
		$display("t_untimed done");
	endtask
	task automatic t_timed();
		for (int i = 0; i < 2; i++) begin
			wr(hsc_pkg::REG_CTRL, i ? 32'h6 : 32'h9);
			wr(hsc_pkg::REG_TIMES, {6'h0, 10'd5, 6'h0, i ? 10'd0 : 10'd3});
			wr(hsc_pkg::REG_COOL, 32'h2);
			meas.actualTemp <= 16'h0050;
			req[0] <= 1'b1;
			wt(AX, 1'b1, 15);
			wt(HE, 1'b1, 20);
			chk(32'(n <= (i ? 0 : 3 * UN) + 2 && n + 2 >= (i ? 0 : 3 * UN)), 32'h1);
			wt(HE, 1'b0, 40);
			chk(32'(n >= 5 * UN - 2 && n <= 5 * UN + 2), 32'h1);
			cyc(2);
			meas.actualTemp <= 16'h0011;
			wt(AX, 1'b0, 20);
			cyc(3);
			chk(32'(dispTemp), 32'h50);
			cyc(30);
			chk(32'(status.auxRelay), 32'h0);
			chk(32'(dispTemp), i ? 32'h50 : 32'h11);
			req[0] <= 1'b0;
			cyc(10);
		end
		rdc(hsc_pkg::REG_COUNT, 32'h3FFFFFFF, 32'h3);
		$display("t_timed done");
	endtask
	task automatic t_manual();
		wr(hsc_pkg::REG_CTRL, 32'h15);
		meas.actualTemp <= 16'h0066;
		req[4] <= 1'b1;
		wt(HE, 1'b1, 20);
		wt(HE, 1'b0, 40);
		chk(32'(n >= 5 * UN - 2 && n <= 5 * UN + 2), 32'h1);
		wt(HL, 1'b0, 10);
		wt(HL, 1'b1, 20);
		chk(32'(n >= BLK - 2 && n <= BLK + 2), 32'h1);
		chk(32'(dispTemp), 32'h66);
		req[4] <= 1'b0;
		cyc(30);
		wr(hsc_pkg::REG_CTRL, 32'h05);
		req[4] <= 1'b1;
		wt(HE, 1'b1, 20);
		chk(32'(status.auxRelay), 32'h0);
		req[4] <= 1'b0;
		wt(HE, 1'b0, 20);
		rdc(hsc_pkg::REG_COUNT, 32'h3FFFFFFF, 32'h3);
		$display("t_manual done");
	endtask
	task automatic t_cal();
		meas.errorCode <= 10'h065;
		meas.actualTemp <= 16'h0055;
		req[2] <= 1'b1;
		wt(CA, 1'b1, 15);
		req[2] <= 1'b0;
		cyc(2);
		chk(32'(tempOut), 32'h0);
		chk(32'(calCount), 32'hD);
		req[1:0] <= 2'h3;
		cyc(20);
		req[1] <= 1'b0;
		chk(32'(status.calibrating), 32'h1);
		wt(CA, 1'b0, 14 * CAL + 10);
		cyc(10);
		chk(32'(status.heatEnable), 32'h0);
		req[0] <= 1'b0;
		meas.errorCode <= 10'h000;
		cyc(RI + 20);
		$display("t_cal done");
	endtask
	task automatic t_alarm();
		logic [15:0] tt[5] = '{16'h005E, 16'h005F, 16'h0064, 16'h006A, 16'h006B};
		wr(hsc_pkg::REG_WINDOW, 32'h0605);
		for (int i = 0; i < 5; i++) begin
			meas.actualTemp <= tt[i];
			cyc(4);
			chk(32'(status.tempOk), 32'(i > 0 && i < 4));
		end
		meas.alarmActive <= 1'b1;
		meas.errorCode <= 10'h068;
		cyc(4);
		chk(32'(status.tempOk), 32'h0);
		req[0] <= 1'b1;
		wt(AR, 1'b1, 20);
		chk(32'(status.heatEnable), 32'h0);
		req[0] <= 1'b0;
		meas.alarmActive <= 1'b0;
		meas.errorCode <= 10'h000;
		req[1] <= 1'b1;
		wt(AC, 1'b1, 15);
		cyc(15);
		chk(32'(status.alarmRelay || status.measureEnable), 32'h0);
		late <= 1'b1;
		req[1] <= 1'b0;
		cyc(RI + 20);
		chk(32'(status.contactorAlarm), 32'h1);
		late <= 1'b0;
		req[1] <= 1'b1;
		cyc(12);
		req[1] <= 1'b0;
		cyc(RI + 20);
		chk(32'(status.contactorAlarm), 32'h0);
		for (int i = 0; i < 2; i++) begin
			wr(hsc_pkg::REG_SETPT, 32'h28 + i);
			req[0] <= 1'b1;
			cyc(15);
			chk(32'(status.heatEnable), 32'(i));
			req[0] <= 1'b0;
			cyc(15);
		end
		$display("t_alarm done");
	endtask
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_lock();
		t_untimed();
		t_timed();
		t_manual();
		t_cal();
		t_alarm();
		wrapUp();
	end
	initial begin
		repeat (20000) @(posedge clk);
		errCount++;
		wrapUp();
	end
endmodule // testbench
`default_nettype wire
